// ===== core/ext_irq_edge_flag.sv
// request pin edge detection, request flags and stack word helpers
// assumes an axi4-lite master on aclk and asynchronous pins
// Operation
// - word accesses force address bit 0 to zero
// - condition codes pushed as a word, restored from the even byte
// - select 0 to 1 with pin low and falling sense sets flag
// - select 1 to 0 with pin low and rising sense sets flag
// - wake pins show the same false edges via their select and edge bits
// - event source switch with differing levels counts as an edge
// - flag clear right after a select write is ignored
// - byte write clears every flag written as 0, even new ones
// - flags clear only by writing 0; writing 1 leaves them
// - wake edge bit 0 falling, 1 rising, resets to 0
// - selected wake edge on an assigned pin sets its wake flag
`timescale 1ns/1ps
module ext_irq_edge_flag (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        line0_pin_n,
  input  wire logic        line1_pin_n,
  input  wire logic        line3_pin_n,
  input  wire logic        line4_pin_n,
  input  wire logic        event_counter_input_pin,
  input  wire logic [7:0]  wake_input_pin_n,
  input  wire logic        internal_pwm_event_signal,
  input  wire logic        stack_word_access,
  input  wire logic [15:0] stack_addr,
  output logic [15:0]      stack_mem_addr,
  input  wire logic        exception_entry,
  input  wire logic [7:0]  condition_code_register,
  output logic [15:0]      ccr_push_word,
  input  wire logic        return_from_exception,
  input  wire logic [15:0] ccr_pop_word,
  output logic [7:0]       ccr_restored,
  output logic             irq
);
  logic [7:0]  pin_function_select_a;
  logic [7:0]  pin_function_select_b;
  logic [7:0]  pin_function_select_c;
  logic [7:0]  wake_pin_function_select;
  logic [7:0]  request_edge_select_reg;
  logic [7:0]  wake_edge_select_reg;
  logic [7:0]  event_edge_config_reg;
  logic [12:0] flags;
  logic [12:0] irq_status;
  logic [12:0] irq_mask;
  logic [12:0] pin_meta;
  logic [12:0] pin_sync;
  logic [12:0] fsel;
  logic [12:0] lvl;
  logic [12:0] rise_en;
  logic [12:0] fall_en;
  logic [12:0] hit;
  logic [12:0] flag_keep;
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  waddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        do_write;
  logic        ar_fire;
  logic        just_switched;
  logic        flag_write;
  logic        sel_write;
  ext_irq_pkg::reg_sel_e wsel;
  ext_irq_pkg::reg_sel_e rsel;

  // address decode shared by the read and write paths
  function automatic ext_irq_pkg::reg_sel_e decode(input logic [7:0] a);
    unique case (a)
      ext_irq_pkg::OFS_FSEL_A:     decode = ext_irq_pkg::SEL_FSEL_A;
      ext_irq_pkg::OFS_FSEL_B:     decode = ext_irq_pkg::SEL_FSEL_B;
      ext_irq_pkg::OFS_FSEL_C:     decode = ext_irq_pkg::SEL_FSEL_C;
      ext_irq_pkg::OFS_WAKE_FSEL:  decode = ext_irq_pkg::SEL_WAKE_FSEL;
      ext_irq_pkg::OFS_REQ_EDGE:   decode = ext_irq_pkg::SEL_REQ_EDGE;
      ext_irq_pkg::OFS_WAKE_EDGE:  decode = ext_irq_pkg::SEL_WAKE_EDGE;
      ext_irq_pkg::OFS_EVENT_CFG:  decode = ext_irq_pkg::SEL_EVENT_CFG;
      ext_irq_pkg::OFS_REQ_FLAG:   decode = ext_irq_pkg::SEL_REQ_FLAG;
      ext_irq_pkg::OFS_WAKE_FLAG:  decode = ext_irq_pkg::SEL_WAKE_FLAG;
      ext_irq_pkg::OFS_IRQ_STATUS: decode = ext_irq_pkg::SEL_IRQ_STATUS;
      ext_irq_pkg::OFS_IRQ_MASK:   decode = ext_irq_pkg::SEL_IRQ_MASK;
      default:                     decode = ext_irq_pkg::SEL_NONE;
    endcase
  endfunction : decode

  // byte-lane merge of a write into an old value
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  // write channel capture, address and data in either order
  assign awready  = !aw_hold && !bvalid;
  assign wready   = !w_hold && !bvalid;
  assign do_write = aw_hold && w_hold && !bvalid;
  assign wsel     = decode(waddr_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_hold <= 1'b1;
        waddr_q <= awaddr;
      end
      else if (do_write)
        aw_hold <= 1'b0;
      if (wvalid && wready)
      begin
        w_hold  <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      else if (do_write)
        w_hold <= 1'b0;
    end
  end

  // write response raised on the same edge that the write lands
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= ext_irq_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      bresp  <= (wsel == ext_irq_pkg::SEL_NONE) ? ext_irq_pkg::RESP_SLVERR : ext_irq_pkg::RESP_OKAY;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_function_select_a    <= ext_irq_pkg::RST_BYTE;
      pin_function_select_b    <= ext_irq_pkg::RST_BYTE;
      pin_function_select_c    <= ext_irq_pkg::RST_BYTE;
      wake_pin_function_select <= ext_irq_pkg::RST_BYTE;
      request_edge_select_reg  <= ext_irq_pkg::RST_BYTE;
      wake_edge_select_reg     <= ext_irq_pkg::RST_WAKE_EDGE;
      event_edge_config_reg    <= ext_irq_pkg::RST_BYTE;
      irq_mask                 <= ext_irq_pkg::RST_LINES;
    end
    else if (do_write && wstrb_q[0])
    begin
      unique case (wsel)
        ext_irq_pkg::SEL_FSEL_A:    pin_function_select_a    <= wdata_q[7:0];
        ext_irq_pkg::SEL_FSEL_B:    pin_function_select_b    <= wdata_q[7:0];
        ext_irq_pkg::SEL_FSEL_C:    pin_function_select_c    <= wdata_q[7:0];
        ext_irq_pkg::SEL_WAKE_FSEL: wake_pin_function_select <= wdata_q[7:0];
        ext_irq_pkg::SEL_REQ_EDGE:  request_edge_select_reg  <= wdata_q[7:0];
        ext_irq_pkg::SEL_WAKE_EDGE: wake_edge_select_reg     <= wdata_q[7:0];
        ext_irq_pkg::SEL_EVENT_CFG: event_edge_config_reg    <= wdata_q[7:0];
        ext_irq_pkg::SEL_IRQ_MASK:  irq_mask <= 13'(merge({3'h0, irq_mask}, wdata_q, wstrb_q));
        default:                    irq_mask <= irq_mask;
      endcase
    end
  end

  // a select write arms the guard; the next bus transaction disarms it
  assign sel_write  = do_write && wstrb_q[0] && (wsel inside {ext_irq_pkg::SEL_FSEL_A, ext_irq_pkg::SEL_FSEL_B,
                      ext_irq_pkg::SEL_FSEL_C, ext_irq_pkg::SEL_WAKE_FSEL, ext_irq_pkg::SEL_EVENT_CFG});
  assign flag_write = do_write && wstrb_q[0] && !just_switched &&
                      (wsel == ext_irq_pkg::SEL_REQ_FLAG || wsel == ext_irq_pkg::SEL_WAKE_FLAG);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      just_switched <= 1'b0;
    else if (sel_write)
      just_switched <= 1'b1;
    else if (do_write || ar_fire)
      just_switched <= 1'b0;
  end

  // two-flop synchronisers for all pins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_meta <= {13{ext_irq_pkg::PIN_IDLE}};
      pin_sync <= {13{ext_irq_pkg::PIN_IDLE}};
    end
    else
    begin
      pin_meta <= {wake_input_pin_n, line4_pin_n, line3_pin_n, event_counter_input_pin, line1_pin_n, line0_pin_n};
      pin_sync <= pin_meta;
    end
  end

  // function selects and edge enables per detector line
  assign fsel = {wake_pin_function_select, pin_function_select_a[4], pin_function_select_a[3], 1'b1,
                 pin_function_select_c[1], pin_function_select_b[0]};

  always_comb
  begin
    for (int i = 0; i < ext_irq_pkg::LINES; i++)
      lvl[i] = fsel[i] ? pin_sync[i] : ext_irq_pkg::PIN_IDLE;
    // request lines use the request edge bits, wake lines their own bits
    for (int i = 0; i < ext_irq_pkg::WAKE_LSB; i++)
      rise_en[i] = request_edge_select_reg[i];
    for (int i = ext_irq_pkg::WAKE_LSB; i < ext_irq_pkg::LINES; i++)
      rise_en[i] = wake_edge_select_reg[i - ext_irq_pkg::WAKE_LSB];
    fall_en = ~rise_en;
    // event line: source mux, switching counts as an edge
    lvl[ext_irq_pkg::BIT_EVENT]     = event_edge_config_reg[ext_irq_pkg::EV_SRC] ? internal_pwm_event_signal
                                                                                   : pin_sync[ext_irq_pkg::BIT_EVENT];
    rise_en[ext_irq_pkg::BIT_EVENT] = event_edge_config_reg[ext_irq_pkg::EV_MODE_HI] ||
                                      event_edge_config_reg[ext_irq_pkg::EV_MODE_LO];
    fall_en[ext_irq_pkg::BIT_EVENT] = event_edge_config_reg[ext_irq_pkg::EV_MODE_HI] ||
                                      !event_edge_config_reg[ext_irq_pkg::EV_MODE_LO];
  end

  genvar g;
  generate
    for (g = 0; g < ext_irq_pkg::LINES; g++)
    begin : g_det
      edge_sense u_det (
        .aclk    (aclk),
        .aresetn (aresetn),
        .level   (lvl[g]),
        .rise_en (rise_en[g]),
        .fall_en (fall_en[g]),
        .hit     (hit[g])
      );
    end
  endgenerate

  // bits a flag write keeps: written 1 keeps, written 0 clears
  always_comb
  begin
    flag_keep = {13{1'b1}};
    if (flag_write && wsel == ext_irq_pkg::SEL_REQ_FLAG)
      flag_keep[4:0] = wdata_q[4:0];
    if (flag_write && wsel == ext_irq_pkg::SEL_WAKE_FLAG)
      flag_keep[12:5] = wdata_q[7:0];
  end

  // request and wake flags, a new edge wins over a clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags <= ext_irq_pkg::RST_LINES;
    else
      flags <= (flags & flag_keep) | hit;
  end

  // sticky status cleared by reading it, set wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_status <= ext_irq_pkg::RST_LINES;
    else if (ar_fire && rsel == ext_irq_pkg::SEL_IRQ_STATUS)
      irq_status <= hit;
    else
      irq_status <= irq_status | hit;
  end

  assign irq = |(irq_status & irq_mask);

  // read channel, one cycle to rvalid
  assign arready = !rvalid;
  assign ar_fire = arvalid && arready;
  assign rsel    = decode(araddr);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= ext_irq_pkg::RESP_OKAY;
    end
    else if (ar_fire)
    begin
      rvalid <= 1'b1;
      rresp  <= (rsel == ext_irq_pkg::SEL_NONE) ? ext_irq_pkg::RESP_SLVERR : ext_irq_pkg::RESP_OKAY;
      unique case (rsel)
        ext_irq_pkg::SEL_FSEL_A:     rdata <= {24'h000000, pin_function_select_a};
        ext_irq_pkg::SEL_FSEL_B:     rdata <= {24'h000000, pin_function_select_b};
        ext_irq_pkg::SEL_FSEL_C:     rdata <= {24'h000000, pin_function_select_c};
        ext_irq_pkg::SEL_WAKE_FSEL:  rdata <= {24'h000000, wake_pin_function_select};
        ext_irq_pkg::SEL_REQ_EDGE:   rdata <= {24'h000000, request_edge_select_reg};
        ext_irq_pkg::SEL_WAKE_EDGE:  rdata <= {24'h000000, wake_edge_select_reg};
        ext_irq_pkg::SEL_EVENT_CFG:  rdata <= {24'h000000, event_edge_config_reg};
        ext_irq_pkg::SEL_REQ_FLAG:   rdata <= {27'h0000000, flags[4:0]};
        ext_irq_pkg::SEL_WAKE_FLAG:  rdata <= {24'h000000, flags[12:5]};
        ext_irq_pkg::SEL_IRQ_STATUS: rdata <= {19'h00000, irq_status};
        ext_irq_pkg::SEL_IRQ_MASK:   rdata <= {19'h00000, irq_mask};
        ext_irq_pkg::SEL_NONE:       rdata <= 32'h0000_0000;
      endcase
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // stack word address and condition code save and restore
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stack_mem_addr <= 16'h0000;
      ccr_push_word  <= 16'h0000;
      ccr_restored   <= 8'h00;
    end
    else
    begin
      stack_mem_addr <= stack_word_access ? {stack_addr[15:1], 1'b0} : stack_addr;
      if (exception_entry)
        ccr_push_word <= {condition_code_register, condition_code_register};
      if (return_from_exception)
        ccr_restored <= ccr_pop_word[15:8]; // even byte sits high
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_word_even;
    stack_word_access |=> stack_mem_addr == {$past(stack_addr[15:1]), 1'b0};
  endproperty
  a_word_even: assert property (p_word_even) else $error("word address not even");

  property p_ccr_restore;
    return_from_exception |=> ccr_restored == $past(ccr_pop_word[15:8]);
  endproperty
  a_ccr_restore: assert property (p_ccr_restore) else $error("ccr not from even byte");

  property p_sel_rise_fall;
    $rose(fsel[0]) && !pin_sync[0] && !request_edge_select_reg[0] |=> flags[0];
  endproperty
  a_sel_rise_fall: assert property (p_sel_rise_fall) else $error("select rise missed false edge");

  property p_sel_fall_rise;
    $fell(fsel[1]) && !$past(pin_sync[1]) && request_edge_select_reg[1] |=> flags[1];
  endproperty
  a_sel_fall_rise: assert property (p_sel_fall_rise) else $error("select fall missed false edge");

  property p_wake_false;
    $rose(wake_pin_function_select[7]) && !pin_sync[12] && !wake_edge_select_reg[7] |=> flags[12] ##1 flags[12];
  endproperty
  a_wake_false: assert property (p_wake_false) else $error("wake false edge lost");

  property p_event_switch;
    $changed(event_edge_config_reg[2]) && event_edge_config_reg[1] && lvl[2] != $past(lvl[2]) |=> flags[2];
  endproperty
  a_event_switch: assert property (p_event_switch) else $error("source switch edge lost");

  property p_clear_blocked;
    do_write && just_switched && wsel == ext_irq_pkg::SEL_REQ_FLAG |=> flags == ($past(flags) | $past(hit));
  endproperty
  a_clear_blocked: assert property (p_clear_blocked) else $error("clear honoured too early");

  property p_clear_write;
    flag_write && wsel == ext_irq_pkg::SEL_REQ_FLAG
      |=> flags[4:0] == (($past(flags[4:0]) & $past(wdata_q[4:0])) | $past(hit[4:0]));
  endproperty
  a_clear_write: assert property (p_clear_write) else $error("flag byte write wrong");

  property p_set_cause;
    $rose(flags[12]) |-> $past(hit[12]);
  endproperty
  a_set_cause: assert property (p_set_cause) else $error("flag set without edge");
endmodule : ext_irq_edge_flag

// ===== core/ext_irq_pkg.sv
// constants for the external request edge and flag block
// assumes a 32-bit axi4-lite slave port with an 8-bit byte address
package ext_irq_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_FSEL_A     = 8'h00;
  localparam logic [7:0] OFS_FSEL_B     = 8'h04;
  localparam logic [7:0] OFS_FSEL_C     = 8'h08;
  localparam logic [7:0] OFS_WAKE_FSEL  = 8'h0C;
  localparam logic [7:0] OFS_REQ_EDGE   = 8'h10;
  localparam logic [7:0] OFS_WAKE_EDGE  = 8'h14;
  localparam logic [7:0] OFS_EVENT_CFG  = 8'h18;
  localparam logic [7:0] OFS_REQ_FLAG   = 8'h1C;
  localparam logic [7:0] OFS_WAKE_FLAG  = 8'h20;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h28;

  // detector line positions in the 13-bit event vector
  localparam int LINES      = 13;
  localparam int BIT_LINE0  = 0;
  localparam int BIT_LINE1  = 1;
  localparam int BIT_EVENT  = 2;
  localparam int BIT_LINE3  = 3;
  localparam int BIT_LINE4  = 4;
  localparam int WAKE_LSB   = 5;

  // event_edge_config_reg field positions
  localparam int EV_MODE_LO = 0;
  localparam int EV_MODE_HI = 1;
  localparam int EV_SRC     = 2;

  // values after reset
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [7:0]  RST_WAKE_EDGE = 8'h00;
  localparam logic [12:0] RST_LINES     = 13'h0000;
  localparam logic        PIN_IDLE      = 1'b1;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {
    SEL_FSEL_A, SEL_FSEL_B, SEL_FSEL_C, SEL_WAKE_FSEL, SEL_REQ_EDGE, SEL_WAKE_EDGE,
    SEL_EVENT_CFG, SEL_REQ_FLAG, SEL_WAKE_FLAG, SEL_IRQ_STATUS, SEL_IRQ_MASK, SEL_NONE
  } reg_sel_e;
endpackage : ext_irq_pkg

// ===== core/edge_sense.sv
// one edge detector on an already synchronised level
// assumes level is clean in the aclk domain
`timescale 1ns/1ps
module edge_sense (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic level,
  input  wire logic rise_en,
  input  wire logic fall_en,
  output logic      hit
);
  logic prev;

  // previous level, idle high like an unused pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prev <= ext_irq_pkg::PIN_IDLE;
    else
      prev <= level;
  end

  // selected transition seen this cycle
  assign hit = (rise_en & level & ~prev) | (fall_en & ~level & prev);
endmodule : edge_sense

// ===== bench/ext_pin_model.sv
// pin-side model: request, wake and event pins plus the pwm level
// assumes the bench sets wanted levels just after a rising aclk edge
`timescale 1ns/1ps
module ext_pin_model (
  input  wire logic       aclk,
  input  wire logic [3:0] req_lvl,
  input  wire logic [7:0] wake_lvl,
  input  wire logic       ev_lvl,
  input  wire logic       pwm_lvl,
  output logic            line0_pin_n,
  output logic            line1_pin_n,
  output logic            line3_pin_n,
  output logic            line4_pin_n,
  output logic [7:0]      wake_input_pin_n,
  output logic            event_counter_input_pin,
  output logic            internal_pwm_event_signal
);
  // pins move only at a clock edge, like a board-level driver
  always_ff @(posedge aclk)
  begin
    line0_pin_n               <= req_lvl[0];
    line1_pin_n               <= req_lvl[1];
    line3_pin_n               <= req_lvl[2];
    line4_pin_n               <= req_lvl[3];
    wake_input_pin_n          <= wake_lvl;
    event_counter_input_pin   <= ev_lvl;
    internal_pwm_event_signal <= pwm_lvl;
  end
endmodule : ext_pin_model

// ===== bench/ext_irq_edge_flag_tb_top.sv
// bench for the request edge and flag block, driven over axi4-lite
// assumes the pin model sits on the pins; one 100 mhz clock
`timescale 1ns/1ps
module ext_irq_edge_flag_tb_top;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq, ev_lvl, pwm_lvl;
  logic        line0_pin_n, line1_pin_n, line3_pin_n, line4_pin_n;
  logic        event_counter_input_pin, internal_pwm_event_signal;
  logic        stack_word_access, exception_entry, return_from_exception;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  wstrb, req_lvl;
  logic [7:0]  awaddr, araddr, wake_input_pin_n, wake_lvl, condition_code_register, ccr_restored;
  logic [15:0] stack_addr, stack_mem_addr, ccr_push_word, ccr_pop_word;
  logic [31:0] wdata, rdata, rd;
  int          fails, checks_done;
  localparam logic [7:0] FLG = ext_irq_pkg::OFS_REQ_FLAG;
  localparam logic [7:0] WFL = ext_irq_pkg::OFS_WAKE_FLAG;
  localparam logic [7:0] CFG = ext_irq_pkg::OFS_EVENT_CFG;

  ext_irq_edge_flag ext_irq_edge_flag_i (.*);
  ext_pin_model     ext_pin_model_i (.*);

  // free-running 100 mhz clock
  always #5 aclk = ~aclk;

  task automatic close_out;
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one clock edge with a bound on the whole wait
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 60)
    begin
      fails++;
      close_out();
    end
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int   n = 0;
    logic aw_ok = 1'b0;
    logic w_ok = 1'b0;
    logic got = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!got)
    begin
      tick(n);
      if (!aw_ok && awready)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid)
      begin
        got = 1'b1;
        resp = bresp;
      end
    end
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    int   n = 0;
    logic got = 1'b0;
    araddr  <= a;
    arvalid <= 1'b1;
    while (!got)
    begin
      tick(n);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        got = 1'b1;
        rd = rdata;
        resp = rresp;
      end
    end
  endtask : rdr

  // pin change needs sync plus detector plus flag edges
  task automatic settle;
    repeat (8) @(posedge aclk);
  endtask : settle

  // main sequence
  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b1;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b1;
    req_lvl = 4'hF;
    wake_lvl = 8'hFF;
    ev_lvl = 1'b1;
    pwm_lvl = 1'b1;
    stack_word_access = 1'b0;
    stack_addr = 16'h0;
    exception_entry = 1'b0;
    condition_code_register = 8'h00;
    return_from_exception = 1'b0;
    ccr_pop_word = 16'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values and an unmapped place
    rdr(ext_irq_pkg::OFS_WAKE_EDGE);
    check(rd, 32'h0);
    rdr(FLG);
    check(rd, 32'h0);
    rdr(8'hFC);
    check({rd[29:0], resp}, {30'h0, ext_irq_pkg::RESP_SLVERR});
    // line0 low while unassigned, then assigned under falling sense
    req_lvl <= 4'hE;
    settle();
    wr(ext_irq_pkg::OFS_FSEL_B, 32'h1);
    check(resp, ext_irq_pkg::RESP_OKAY);
    wr(FLG, 32'h0);
    rdr(FLG);
    check(rd, 32'h1);
    // line1 rising sense: assign gives nothing, release sets the flag
    wr(ext_irq_pkg::OFS_REQ_EDGE, 32'h2);
    req_lvl <= 4'hC;
    wr(ext_irq_pkg::OFS_FSEL_C, 32'h2);
    rdr(FLG);
    check(rd, 32'h1);
    wr(ext_irq_pkg::OFS_FSEL_C, 32'h0);
    rdr(FLG);
    check(rd, 32'h3);
    wr(FLG, 32'h1F);
    rdr(FLG);
    check(rd, 32'h3);
    wr(FLG, 32'h1D);
    rdr(FLG);
    check(rd, 32'h1);
    // new edge on line0 unseen by software, cleared by a byte write
    req_lvl <= 4'hD;
    settle();
    req_lvl <= 4'hC;
    settle();
    wr(FLG, 32'h1E);
    rdr(FLG);
    check(rd, 32'h0);
    // interrupt output: masked, unmasked, cleared by status read
    rdr(ext_irq_pkg::OFS_IRQ_STATUS);
    req_lvl <= 4'hD;
    settle();
    req_lvl <= 4'hC;
    settle();
    check(irq, 1'b0);
    wr(ext_irq_pkg::OFS_IRQ_MASK, 32'h1);
    check(irq, 1'b1);
    rdr(ext_irq_pkg::OFS_IRQ_STATUS);
    check(rd, 32'h1);
    check(irq, 1'b0);
    // wake pins: assign-time edge, then a real rising edge
    wake_lvl <= 8'h7F;
    settle();
    wr(ext_irq_pkg::OFS_WAKE_FSEL, 32'h80);
    rdr(WFL);
    check(rd, 32'h80);
    wr(ext_irq_pkg::OFS_WAKE_EDGE, 32'h08);
    rdr(ext_irq_pkg::OFS_WAKE_EDGE);
    check(rd, 32'h08);
    wr(ext_irq_pkg::OFS_WAKE_FSEL, 32'h88);
    wake_lvl <= 8'h77;
    settle();
    wake_lvl <= 8'h7F;
    settle();
    rdr(WFL);
    check(rd, 32'h88);
    wr(WFL, 32'h00);
    wr(ext_irq_pkg::OFS_WAKE_EDGE, 32'h88);
    wr(ext_irq_pkg::OFS_WAKE_FSEL, 32'h08);
    rdr(WFL);
    check(rd, 32'h80);
    // event source switch between a low pin and a high pwm level
    wr(CFG, 32'h1);
    ev_lvl <= 1'b0;
    settle();
    for (int m = 0; m < 3; m++)
    begin
      wr(CFG, m);
      rdr(FLG);
      wr(FLG, 32'h1B);
      wr(CFG, 32'h4 | m);
      rdr(FLG);
      check(rd & 32'h4, (m != 0) ? 32'h4 : 32'h0);
      wr(FLG, 32'h1B);
      wr(CFG, m);
      rdr(FLG);
      check(rd & 32'h4, (m != 1) ? 32'h4 : 32'h0);
    end
    // stack word address and condition code save and restore
    stack_word_access <= 1'b1;
    stack_addr <= 16'h1235;
    exception_entry <= 1'b1;
    condition_code_register <= 8'hA5;
    return_from_exception <= 1'b1;
    ccr_pop_word <= 16'h3C77;
    @(posedge aclk);
    exception_entry <= 1'b0;
    return_from_exception <= 1'b0;
    @(posedge aclk);
    check(stack_mem_addr, 16'h1234);
    check(ccr_push_word, 16'hA5A5);
    check(ccr_restored, 8'h3C);
    stack_word_access <= 1'b0;
    repeat (2) @(posedge aclk);
    check(stack_mem_addr, 16'h1235);
    close_out();
  end
endmodule : ext_irq_edge_flag_tb_top
